/* logic/flash_pin_pkg.sv */
// shared constants of the serial flash pin front end
// assumes a 10 MHz system clock and pins sampled through two flip-flops
package flash_pin_pkg;

    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int MCLK_MHZ      = 10;
    localparam int PROG_TIME_US  = 20;
    localparam int ERASE_TIME_US = 30;

    // ---------------------------------------------------------------
    // array geometry
    // ---------------------------------------------------------------
    localparam int PAGES    = 1024;
    localparam int PAGE_STD = 264;
    localparam int PAGE_BIN = 256;
    localparam int PAGE_AW  = 10;
    localparam int BUF_AW   = 9;
    localparam int SECTORS  = 8;
    localparam int SEC_AW   = 3;

    localparam logic [BUF_AW-1:0] BUF_LAST_STD = BUF_AW'(PAGE_STD - 1);
    localparam logic [BUF_AW-1:0] BUF_LAST_BIN = BUF_AW'(PAGE_BIN - 1);

    // ---------------------------------------------------------------
    // framing counts
    // ---------------------------------------------------------------
    localparam logic [2:0] BIT_LAST   = 3'h7;
    localparam logic [1:0] ABYTE_LAST = 2'h2;

    // ---------------------------------------------------------------
    // status byte bit positions
    // ---------------------------------------------------------------
    localparam int ST_READY = 7;
    localparam int ST_WP    = 2;
    localparam int ST_PROT  = 1;
    localparam int ST_BIN   = 0;

    // ---------------------------------------------------------------
    // synchronised pin vector
    // ---------------------------------------------------------------
    localparam int PIN_W   = 6;
    localparam int PIN_SCK = 0;
    localparam int PIN_SI  = 1;
    localparam int PIN_CS  = 2;
    localparam int PIN_WP  = 3;
    localparam int PIN_RES = 4;
    localparam int PIN_BIN = 5;
    // select, write protect and reset read inactive until sampled
    localparam logic [PIN_W-1:0] PIN_INIT = 6'h1C;

endpackage : flash_pin_pkg

/* logic/pin_sync.sv */
// two flip-flop synchroniser for a vector of asynchronous pins
// assumes each bit is an independent level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int             W    = 1,
    parameter logic [W-1:0]   INIT = '0
) (
    input  wire logic         mclk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    typedef struct packed {
        logic [W-1:0] s2;
        logic [W-1:0] s1;
    } sync_t;

    sync_t q;
    sync_t d;

    always_comb begin
        d.s1 = d_i;
        d.s2 = q.s1;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            q <= {INIT, INIT};
        end else begin
            q <= d;
        end
    end

    assign q_o = q.s2;

    property p_two_stage;
        @(posedge mclk_i) disable iff (!rst_n_i)
        $past(rst_n_i, 2) |-> q_o == $past(d_i, 2);
    endproperty
    a_sync_two_stage: assert property (p_two_stage)
        else $error("synchroniser delay is not two cycles");

endmodule : pin_sync

`default_nettype wire

/* logic/page_buffer.sv */
// page-sized data buffer, one write port, registered read port
// assumes write address and data are stable in the write cycle
`timescale 1ns/1ps
`default_nettype none

module page_buffer #(
    parameter int DW    = 8,
    parameter int DEPTH = 264,
    parameter int AW    = 9
) (
    input  wire logic          mclk_i,
    input  wire logic          rst_n_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);

    logic [DW-1:0] mem [DEPTH];

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end

    // last write, kept for the read-back check only
    logic [AW-1:0] chk_addr_q;
    logic [DW-1:0] chk_data_q;

    always_ff @(posedge mclk_i) begin
        if (we_i) begin
            chk_addr_q <= waddr_i;
            chk_data_q <= wdata_i;
        end
    end

    property p_write_read;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (!we_i && raddr_i == chk_addr_q) |=> rdata_o == chk_data_q;
    endproperty
    a_buf_write_read: assert property (p_write_read) // RQ18
        else $error("buffer read does not return written byte");

endmodule : page_buffer

`default_nettype wire

/* logic/serial_flash_pin_interface.sv */
// pin-level front end of a serial flash with one page buffer
// assumes all pins are asynchronous; shift clock far slower than mclk_i
// Behaviour
// (RQ1) deselected: standby, output released
// (RQ2) ignore serial input while deselected
// (RQ3) select fall starts, select rise ends operation
// (RQ4) stay active until self-timed work ends
// (RQ5) sample input on shift clock rise
// (RQ6) update output on shift clock fall
// (RQ7) all command content arrives on serial input
// (RQ8) write protect low guards flagged sectors
// (RQ9) hardware guard independent of software enable
// (RQ10) protection flags frozen while write protect low
// (RQ11) program/erase under write protect discarded
// (RQ12) enable protection and lockdown still accepted
// (RQ13) floating write protect reads not asserted
// (RQ14) reset pin low aborts, forces idle
// (RQ15) held in reset while pin low
// (RQ16) internal power-on reset, no pin sequencing
// (RQ17) host ties unused reset pin high
// (RQ18) 1024 pages of 256/264 bytes, one buffer
// (RQ19) program and erase self-timed internally
// (RQ20) first byte after select is opcode
// (RQ21) bytes shifted most significant bit first
// (RQ22) shift clock modes 0 and 3
// (RQ23) reset discards partial bits, releases output
// (RQ24) busy while self-timed, refuse array commands
`timescale 1ns/1ps
`default_nettype none

module serial_flash_pin_interface
    import flash_pin_pkg::*;
#(
    parameter logic [7:0] OP_BUF_WR    = 8'h10,
    parameter logic [7:0] OP_BUF_RD    = 8'h11,
    parameter logic [7:0] OP_PROG      = 8'h20,
    parameter logic [7:0] OP_ERASE     = 8'h21,
    parameter logic [7:0] OP_STATUS    = 8'h30,
    parameter logic [7:0] OP_PROT_WR   = 8'h40,
    parameter logic [7:0] OP_PROT_EN   = 8'h41,
    parameter logic [7:0] OP_PROT_DIS  = 8'h42,
    parameter logic [7:0] OP_LOCK      = 8'h43,
    parameter int         PROG_CYCLES  = PROG_TIME_US * MCLK_MHZ,
    parameter int         ERASE_CYCLES = ERASE_TIME_US * MCLK_MHZ
) (
    input  wire logic               mclk_i,
    input  wire logic               rst_n_i,
    input  wire logic               sck_i,
    input  wire logic               si_i,
    input  wire logic               cs_n_i,
    input  wire logic               wp_n_i,
    input  wire logic               hw_rst_n_i,
    input  wire logic               page_bin_i,
    output logic                    so_o,
    output logic                    so_oe_o,
    output logic                    busy_o,
    output logic                    standby_o,
    output logic                    arr_start_o,
    output logic                    arr_erase_o,
    output logic      [PAGE_AW-1:0] arr_page_o
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        FR_IDLE, FR_OPC, FR_ADDR, FR_WDATA, FR_RDATA, FR_HOLD, FR_DISCARD
    } frame_t;

    typedef struct packed {
        frame_t               fsm;
        logic                 sck_d;
        logic                 cs_d;
        logic [7:0]           sh;
        logic [2:0]           bits;
        logic [7:0]           op;
        logic [23:0]          addr;
        logic [1:0]           abyte;
        logic [BUF_AW-1:0]    bptr;
        logic [7:0]           oreg;
        logic [2:0]           obit;
        logic                 so;
        logic                 so_oe;
        logic                 busy;
        logic [15:0]          cnt;
        logic                 standby;
        logic [SECTORS-1:0]   prot;
        logic [SECTORS-1:0]   lock;
        logic                 sw_en;
        logic                 arr_start;
        logic                 arr_erase;
        logic [PAGE_AW-1:0]   arr_page;
    } state_t;

    localparam state_t RST_STATE = '{fsm: FR_IDLE, cs_d: 1'b1, standby: 1'b1, default: '0};

    state_t q;
    state_t d;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [PAGE_AW-1:0] page_of(input logic [23:0] a, input logic bin);
        page_of = bin ? a[PAGE_AW+7:8] : a[PAGE_AW+8:9];
    endfunction : page_of

    function automatic logic [BUF_AW-1:0] byte_of(input logic [23:0] a, input logic bin);
        byte_of = bin ? {1'b0, a[7:0]} : a[BUF_AW-1:0];
    endfunction : byte_of

    function automatic logic [BUF_AW-1:0] next_ptr(input logic [BUF_AW-1:0] p,
                                                   input logic bin);
        next_ptr = (p == (bin ? BUF_LAST_BIN : BUF_LAST_STD)) ? '0 : p + 1'b1;
    endfunction : next_ptr

    function automatic logic is_array(input logic [7:0] op);
        is_array = (op == OP_PROG) || (op == OP_ERASE);
    endfunction : is_array

    function automatic logic has_addr(input logic [7:0] op);
        has_addr = is_array(op) || op == OP_LOCK || op == OP_BUF_RD || op == OP_BUF_WR;
    endfunction : has_addr

    // ---------------------------------------------------------------
    // pin sampling
    // ---------------------------------------------------------------
    logic [PIN_W-1:0] pins_s;

    // reset values hold the protect and reset pins inactive until they are first sampled
    pin_sync #(
        .W    (PIN_W),
        .INIT (PIN_INIT)        // RQ13 RQ16
    ) i_pin_sync (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({page_bin_i, hw_rst_n_i, wp_n_i, cs_n_i, si_i, sck_i}),
        .q_o     (pins_s)
    );

    logic sck_s, si_s, cs_n_s, wp_n_s, res_n_s, bin_s;
    assign sck_s   = pins_s[PIN_SCK];
    assign si_s    = pins_s[PIN_SI];
    assign cs_n_s  = pins_s[PIN_CS];
    assign wp_n_s  = pins_s[PIN_WP];
    assign res_n_s = pins_s[PIN_RES];
    assign bin_s   = pins_s[PIN_BIN];

    logic sck_rise, sck_fall, cs_fall, cs_rise, byte_done;
    assign sck_rise  = sck_s && !q.sck_d;       // RQ22
    assign sck_fall  = !sck_s && q.sck_d;
    assign cs_fall   = q.cs_d && !cs_n_s;
    assign cs_rise   = !q.cs_d && cs_n_s;
    assign byte_done = sck_rise && q.bits == BIT_LAST;

    // ---------------------------------------------------------------
    // page buffer
    // ---------------------------------------------------------------
    logic       mem_we;
    logic [7:0] mem_rdata;
    logic [7:0] sh_next;
    logic [7:0] status;
    logic [7:0] out_byte;
    logic [23:0] addr_next;

    assign sh_next   = {q.sh[6:0], si_s};       // RQ21
    assign addr_next = {q.addr[15:0], sh_next};

    page_buffer #(
        .DW    (8),
        .DEPTH (PAGE_STD),
        .AW    (BUF_AW)
    ) i_page_buffer (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .we_i    (mem_we),
        .waddr_i (q.bptr),
        .wdata_i (sh_next),
        .raddr_i (q.bptr),
        .rdata_o (mem_rdata)
    );

    always_comb begin
        status           = 8'h00;
        status[ST_READY] = !q.busy;             // RQ24
        status[ST_WP]    = !wp_n_s;
        status[ST_PROT]  = q.sw_en;
        status[ST_BIN]   = bin_s;
    end

    assign out_byte = (q.op == OP_STATUS) ? status : mem_rdata;

    // ---------------------------------------------------------------
    // protection
    // ---------------------------------------------------------------
    logic [PAGE_AW-1:0] pg;
    logic [SEC_AW-1:0]  sec;
    logic               guarded;

    assign pg      = page_of(q.addr, bin_s);    // RQ18
    assign sec     = pg[PAGE_AW-1 -: SEC_AW];
    assign guarded = q.lock[sec] || (q.prot[sec] && (q.sw_en || !wp_n_s)); // RQ8 RQ9

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        d           = q;
        d.sck_d     = sck_s;
        d.cs_d      = cs_n_s;
        d.arr_start = 1'b0;
        mem_we      = 1'b0;
        if (q.busy) begin
            if (q.cnt == 16'h0000) begin
                d.busy = 1'b0;                  // RQ19
            end else begin
                d.cnt = q.cnt - 16'h0001;
            end
        end
        if (sck_rise && q.fsm != FR_IDLE && q.fsm != FR_RDATA) begin
            d.sh   = sh_next;                   // RQ5 RQ7
            d.bits = q.bits + 3'h1;
        end
        unique case (q.fsm)
            FR_IDLE: if (cs_fall) begin         // RQ2 RQ3
                d.fsm   = FR_OPC;
                d.bits  = 3'h0;
                d.abyte = 2'h0;
                d.obit  = 3'h0;
                d.bptr  = '0;
            end
            FR_OPC: if (byte_done) begin        // RQ20
                d.op = sh_next;
                if (is_array(sh_next) && (!wp_n_s || q.busy)) begin
                    d.fsm = FR_DISCARD;         // RQ11 RQ24
                end else if (sh_next == OP_STATUS) begin
                    d.fsm = FR_RDATA;
                end else if (sh_next == OP_PROT_WR) begin
                    d.fsm = FR_WDATA;
                end else if (sh_next == OP_PROT_EN || sh_next == OP_PROT_DIS) begin
                    d.fsm = FR_HOLD;
                end else if (has_addr(sh_next)) begin
                    d.fsm = FR_ADDR;
                end else begin
                    d.fsm = FR_DISCARD;
                end
            end
            FR_ADDR: if (byte_done) begin
                d.addr  = addr_next;
                d.abyte = q.abyte + 2'h1;
                if (q.abyte == ABYTE_LAST) begin
                    d.bptr = byte_of(addr_next, bin_s);
                    if (q.op == OP_BUF_RD) begin
                        d.fsm = FR_RDATA;
                    end else if (q.op == OP_BUF_WR) begin
                        d.fsm = FR_WDATA;
                    end else begin
                        d.fsm = FR_HOLD;
                    end
                end
            end
            FR_WDATA: if (byte_done) begin
                d.bptr = next_ptr(q.bptr, bin_s);
                if (q.op == OP_PROT_WR) begin
                    if (wp_n_s && q.bptr < BUF_AW'(SECTORS)) begin
                        d.prot[q.bptr[SEC_AW-1:0]] = |sh_next;  // RQ10
                    end
                end else begin
                    mem_we = 1'b1;
                end
            end
            FR_RDATA: if (sck_fall) begin       // RQ6 RQ21
                d.so_oe = 1'b1;
                d.obit  = q.obit + 3'h1;
                if (q.obit == 3'h0) begin
                    d.so   = out_byte[7];
                    d.oreg = {out_byte[6:0], 1'b0};
                    if (q.op != OP_STATUS) begin
                        d.bptr = next_ptr(q.bptr, bin_s);
                    end
                end else begin
                    d.so   = q.oreg[7];
                    d.oreg = {q.oreg[6:0], 1'b0};
                end
            end
            FR_HOLD, FR_DISCARD: begin
            end
        endcase
        if (cs_rise && q.fsm != FR_IDLE) begin
            d.fsm   = FR_IDLE;                  // RQ3
            d.so_oe = 1'b0;                     // RQ1
            if (q.fsm == FR_HOLD) begin
                if (is_array(q.op) && wp_n_s && !q.busy && !guarded) begin
                    d.busy      = 1'b1;         // RQ19 RQ24
                    d.cnt       = (q.op == OP_ERASE) ? 16'(ERASE_CYCLES - 1)
                                                     : 16'(PROG_CYCLES - 1);
                    d.arr_start = 1'b1;
                    d.arr_erase = (q.op == OP_ERASE);
                    d.arr_page  = pg;
                end
                if (q.op == OP_PROT_EN) begin
                    d.sw_en = 1'b1;             // RQ12
                end
                if (q.op == OP_PROT_DIS) begin
                    d.sw_en = 1'b0;
                end
                if (q.op == OP_LOCK) begin
                    d.lock[sec] = 1'b1;         // RQ12
                end
            end
        end
        if (!res_n_s) begin                     // RQ14 RQ15 RQ17 RQ23
            d.fsm       = FR_IDLE;
            d.bits      = 3'h0;
            d.abyte     = 2'h0;
            d.busy      = 1'b0;
            d.cnt       = 16'h0000;
            d.so_oe     = 1'b0;
            d.arr_start = 1'b0;
            mem_we      = 1'b0;
        end
        d.standby = cs_n_s && !d.busy;          // RQ1 RQ4
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            q <= RST_STATE;                     // RQ16
        end else begin
            q <= d;
        end
    end

    assign so_o        = q.so;
    assign so_oe_o     = q.so_oe;
    assign busy_o      = q.busy;
    assign standby_o   = q.standby;
    assign arr_start_o = q.arr_start;
    assign arr_erase_o = q.arr_erase;
    assign arr_page_o  = q.arr_page;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_cs_rise;
        !q.cs_d && cs_n_s && res_n_s;
    endsequence

    sequence s_arr_start;
        arr_start_o;
    endsequence

    property p_desel_hiz;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_cs_rise |=> !so_oe_o && q.fsm == FR_IDLE;
    endproperty
    a_desel_hiz: assert property (p_desel_hiz) // RQ1
        else $error("output still driven after deselect");

    a_desel_ignore: assert property ( // RQ2
        @(posedge mclk_i) disable iff (!rst_n_i)
        (q.fsm == FR_IDLE && cs_n_s) |=> $stable(q.sh))
        else $error("input shifted while deselected");

    a_frame_start: assert property ( // RQ3
        @(posedge mclk_i) disable iff (!rst_n_i)
        (q.fsm == FR_IDLE && !cs_fall) |=> q.fsm == FR_IDLE)
        else $error("frame started without select fall");

    a_busy_active: assert property ( // RQ4
        @(posedge mclk_i) disable iff (!rst_n_i)
        (q.busy && q.cnt != 16'h0000 && res_n_s) |=> busy_o && !standby_o)
        else $error("standby entered while self-timed work runs");

    a_sample_rise: assert property ( // RQ5
        @(posedge mclk_i) disable iff (!rst_n_i)
        (sck_rise && q.fsm inside {FR_OPC, FR_ADDR, FR_WDATA} && !cs_rise && res_n_s)
            |=> q.sh == $past(sh_next))
        else $error("input bit not taken on rising edge");

    a_shift_fall: assert property ( // RQ6
        @(posedge mclk_i) disable iff (!rst_n_i)
        $changed(so_o) |-> $past(sck_fall))
        else $error("output changed away from falling edge");

    a_prot_frozen: assert property ( // RQ10
        @(posedge mclk_i) disable iff (!rst_n_i)
        !wp_n_s |=> $stable(q.prot))
        else $error("protection flags changed under write protect");

    a_wp_no_array: assert property ( // RQ11
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_arr_start |-> $past(wp_n_s) && $past(q.fsm) == FR_HOLD)
        else $error("array work started under write protect");

    a_enable_taken: assert property ( // RQ12
        @(posedge mclk_i) disable iff (!rst_n_i)
        (s_cs_rise ##0 (q.fsm == FR_HOLD && q.op == OP_PROT_EN)) |=> q.sw_en)
        else $error("enable protection not accepted");

    a_reset_idle: assert property ( // RQ14
        @(posedge mclk_i) disable iff (!rst_n_i)
        !res_n_s |=> q.fsm == FR_IDLE && !busy_o && !so_oe_o && q.bits == 3'h0)
        else $error("reset pin did not force idle");

    localparam int BUSY_MAX = (PROG_CYCLES > ERASE_CYCLES) ? PROG_CYCLES : ERASE_CYCLES;

    property p_busy_span;
        @(posedge mclk_i) disable iff (!rst_n_i)
        s_arr_start |-> busy_o ##[1:BUSY_MAX] !busy_o;
    endproperty
    a_busy_span: assert property (p_busy_span) // RQ19 RQ24
        else $error("self-timed busy did not end in time");

    a_buf_bound: assert property ( // RQ18
        @(posedge mclk_i) disable iff (!rst_n_i)
        q.bptr <= BUF_LAST_STD)
        else $error("buffer pointer beyond page");

endmodule : serial_flash_pin_interface

`default_nettype wire

/* bench/spi_host.sv */
// host model of the serial link, shift clock mode 0 or 3
// assumes mclk_i at 10 MHz; one shift clock lasts 8 mclk_i cycles
`timescale 1ns/1ps
`default_nettype none

module spi_host (
    input  wire logic       mclk_i,
    input  wire logic       so_i,
    output logic            sck_o,
    output logic            si_o,
    output logic            cs_n_o,
    output logic [7:0]      rx_o,
    output logic            rx_stb_o
);
    logic [7:0] tx [8];
    logic       mode3 = 1'b0;

    initial begin
        sck_o = 1'b0;
        si_o = 1'b0;
        cs_n_o = 1'b1;
        rx_o = 8'h00;
        rx_stb_o = 1'b0;
    end

    // --------------------------------------------------------
    // one frame; sel low shifts with select held high
    // --------------------------------------------------------
    task automatic frame(input bit sel, input int n, input int rd);
        logic [7:0] r;
        r = 8'h00;
        sck_o <= mode3;
        cs_n_o <= ~sel;
        repeat (4) @(posedge mclk_i);
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                sck_o <= 1'b0;
                si_o <= tx[i][b];
                repeat (4) @(posedge mclk_i);
                sck_o <= 1'b1;
                r = {r[6:0], so_i};
                repeat (4) @(posedge mclk_i);
            end
            if (i >= rd) begin
                rx_o <= r;
                rx_stb_o <= 1'b1;
                @(posedge mclk_i);
                rx_stb_o <= 1'b0;
            end
        end
        sck_o <= mode3;
        repeat (4) @(posedge mclk_i);
        cs_n_o <= 1'b1;
        si_o <= ~si_o;
        repeat (8) @(posedge mclk_i);
    endtask : frame
endmodule : spi_host
`default_nettype wire

/* bench/test_serial_flash_pin_interface.sv */
// self-checking bench of the serial flash pin front end
// assumes spi_host as the host; expectations queued, checked by a monitor
`timescale 1ns/1ps
`default_nettype none

module test_serial_flash_pin_interface;
    import flash_pin_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, wp_n = 1'b1, bin = 1'b0;
    logic hw_rst_n = 1'b1;
    logic sck, si, cs_n, so, so_oe, busy, stby, st, er, rx_stb, so_last = 1'b0;
    logic [PAGE_AW-1:0] pg, p;
    logic [7:0] rx, d [4];
    logic [7:0] exp_rx [$];
    logic [10:0] exp_arr [$];
    logic [31:0] s = 32'h424C;
    int n_fail = 0, samples_checked = 0;
    wire so_w = so_oe ? so : ~so_last;

    always #50 mclk = ~mclk;
    always @(posedge mclk) if (so_oe === 1'b1) so_last <= so;

    serial_flash_pin_interface #(.PROG_CYCLES(600)) i_serial_flash_pin_interface (
        .mclk_i(mclk), .rst_n_i(rst_n), .sck_i(sck), .si_i(si), .cs_n_i(cs_n),
        .wp_n_i(wp_n), .hw_rst_n_i(hw_rst_n), .page_bin_i(bin), .so_o(so),
        .so_oe_o(so_oe), .busy_o(busy), .standby_o(stby), .arr_start_o(st),
        .arr_erase_o(er), .arr_page_o(pg));
    spi_host i_spi_host (.mclk_i(mclk), .so_i(so_w), .sck_o(sck), .si_o(si),
        .cs_n_o(cs_n), .rx_o(rx), .rx_stb_o(rx_stb));

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask : check
    task automatic send(input logic [7:0] op, input logic [23:0] a, input int n,
                        input int rd, input bit sel = 1'b1);
        i_spi_host.tx[0] = op;
        {i_spi_host.tx[1], i_spi_host.tx[2], i_spi_host.tx[3]} = a;
        i_spi_host.frame(sel, n, rd);
    endtask : send
    task automatic status(input logic [7:0] e);
        exp_rx.push_back(e);
        exp_rx.push_back(e);
        send(i_serial_flash_pin_interface.OP_STATUS, 24'h0, 3, 1);
    endtask : status
    task automatic end_of_test;
        if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // --------------------------------------------------------
    // monitor: oldest note against each result
    // --------------------------------------------------------
    always @(posedge mclk) begin
        if (rx_stb === 1'b1) check("so_byte", exp_rx.size() ? exp_rx.pop_front() : 'x, rx);
        if (st === 1'b1) check("start", exp_arr.size() ? exp_arr.pop_front() : 'x, {er, pg});
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        check("standby", 1, stby);
        send(i_serial_flash_pin_interface.OP_STATUS, 24'h0, 3, 3, 1'b0);
        check("so_oe", 0, so_oe);
        status(8'h80);
        for (int i = 0; i < 4; i++) begin
            s = lfsr(s);
            d[i] = s[7:0];
            i_spi_host.tx[4 + i] = s[7:0];
        end
        send(i_serial_flash_pin_interface.OP_BUF_WR, {16'h0, s[15:8]}, 8, 8);
        for (int i = 0; i < 4; i++) exp_rx.push_back(d[i]);
        send(i_serial_flash_pin_interface.OP_BUF_RD, {16'h0, s[15:8]}, 8, 4);
        check("so_oe_end", 0, so_oe);
        p = s[25:16];
        exp_arr.push_back({1'b0, p});
        send(i_serial_flash_pin_interface.OP_PROG, {5'h0, p, 9'h0}, 4, 4);
        check("busy", 1, busy);
        check("stby_busy", 0, stby);
        status(8'h00);
        send(i_serial_flash_pin_interface.OP_ERASE, 24'h0, 4, 4);
        for (int i = 0; i < 1000 && busy === 1'b1; i++) @(posedge mclk);
        @(posedge mclk);
        check("stby_done", 1, stby);
        wp_n <= 1'b0;
        repeat (4) @(posedge mclk);
        send(i_serial_flash_pin_interface.OP_PROG, 24'h0, 4, 4);
        check("busy_wp", 0, busy);
        status(8'h84);
        send(i_serial_flash_pin_interface.OP_PROT_EN, 24'h0, 1, 1);
        status(8'h86);
        send(i_serial_flash_pin_interface.OP_LOCK, 24'h070000, 4, 4);
        wp_n <= 1'b1;
        send(i_serial_flash_pin_interface.OP_PROT_WR, 24'hFF0000, 2, 2);
        send(i_serial_flash_pin_interface.OP_PROG, 24'h0, 4, 4);
        send(i_serial_flash_pin_interface.OP_PROT_DIS, 24'h0, 1, 1);
        send(i_serial_flash_pin_interface.OP_PROG, 24'h070000, 4, 4);
        check("busy_prot", 0, busy);
        bin <= 1'b1;
        s = lfsr(s);
        p = {1'b0, s[8:0]};
        exp_arr.push_back({1'b1, p});
        send(i_serial_flash_pin_interface.OP_ERASE, {6'h0, p, 8'h0}, 4, 4);
        hw_rst_n <= 1'b0;
        repeat (5) @(posedge mclk);
        check("busy_rst", 0, busy);
        repeat (10) @(posedge mclk);
        check("busy_hold", 0, busy);
        hw_rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        fork
            send(i_serial_flash_pin_interface.OP_BUF_RD, 24'h0, 8, 8);
            begin
                repeat (300) @(posedge mclk);
                hw_rst_n <= 1'b0;
                repeat (5) @(posedge mclk);
                check("so_oe_rst", 0, so_oe);
                hw_rst_n <= 1'b1;
            end
        join
        i_spi_host.mode3 = 1'b1;
        status(8'h81);
        check("queues", 0, 16'(exp_rx.size() + exp_arr.size()));
        end_of_test();
    end
endmodule : test_serial_flash_pin_interface
`default_nettype wire
